// ### design/pam_pkg.sv
/*
  Constants, register map and state types of the proximity and
  ambient measurement sequencer.
  Assumes a 125 MHz reference clock.
*/
package pam_pkg;

  // Timing
  localparam int CLK_NS        = 8;
  localparam int INTEG_BASE_NS = 25600;
  localparam int BASE_CYC      = INTEG_BASE_NS / CLK_NS;

  // Register offsets
  localparam logic [7:0] A_CMD     = 8'h00;
  localparam logic [7:0] A_RESP    = 8'h01;
  localparam logic [7:0] A_CHANNEL_ENABLE_LIST  = 8'h02;
  localparam logic [7:0] A_LEDSEL  = 8'h03;
  localparam logic [7:0] A_LEDCUR  = 8'h04;
  localparam logic [7:0] A_ICFG    = 8'h05;
  localparam logic [7:0] A_ISTS    = 8'h06;
  localparam logic [7:0] A_PS_RATE = 8'h07;
  localparam logic [7:0] A_AL_RATE = 8'h08;
  localparam logic [7:0] A_VIS_CFG = 8'h09;
  localparam logic [7:0] A_IR_CFG  = 8'h0A;
  localparam logic [7:0] A_PS_THR0 = 8'h0B;
  localparam logic [7:0] A_PS_THR1 = 8'h0C;
  localparam logic [7:0] A_PS_THR2 = 8'h0D;
  localparam logic [7:0] A_AL_LO   = 8'h0E;
  localparam logic [7:0] A_AL_HI   = 8'h0F;
  localparam logic [7:0] A_PS_DAT0 = 8'h10;
  localparam logic [7:0] A_PS_DAT1 = 8'h11;
  localparam logic [7:0] A_PS_DAT2 = 8'h12;
  localparam logic [7:0] A_VIS_DAT = 8'h13;
  localparam logic [7:0] A_IR_DAT  = 8'h14;

  // Command codes
  localparam logic [3:0] C_NOP   = 4'h0;
  localparam logic [3:0] C_PS    = 4'h1;
  localparam logic [3:0] C_ALS   = 4'h2;
  localparam logic [3:0] C_PSALS = 4'h3;
  localparam logic [3:0] C_AUTO  = 4'h4;
  localparam logic [3:0] C_PAUSE = 4'h5;

  // Field positions in the interrupt configuration
  localparam int IC_SET  = 3;
  localparam int IC_ALS  = 4;
  localparam int IC_WIN  = 5;
  localparam int IC_WSEL = 6;

  // ADC channel codes
  localparam logic [1:0] CH_PS  = 2'h0;
  localparam logic [1:0] CH_VIS = 2'h1;
  localparam logic [1:0] CH_IR  = 2'h2;

  // Values after reset
  localparam logic [4:0]  RST_CHANNEL_ENABLE_LIST = 5'h1F;
  localparam logic [8:0]  RST_LEDSEL = 9'h111;
  localparam logic [11:0] RST_LEDCUR = 12'h000;
  localparam logic [3:0]  RST_INTEG  = 4'h0;

  typedef enum logic [1:0] {PAM_IDLE, PAM_PS_NEXT, PAM_AL_NEXT, PAM_CONV} pam_st_e;

  typedef struct packed {
    pam_st_e     st;
    logic [2:0]  idx;
    logic [19:0] cnt;
    logic [19:0] tick;
    logic        auto_ps;
    logic        auto_al;
    logic        pend_ps;
    logic        pend_al;
    logic [15:0] ps_tmr;
    logic [15:0] al_tmr;
    logic [4:0]  channel_enable_list;
    logic [8:0]  ledsel;
    logic [11:0] ledcur;
    logic [6:0]  icfg;
    logic [4:0]  ists;
    logic [2:0]  resp;
    logic [15:0] ps_rate;
    logic [15:0] al_rate;
    logic [3:0]  vis_cfg;
    logic [3:0]  ir_cfg;
    logic [2:0]  ps_above;
    logic [47:0] ps_thr;
    logic [15:0] al_lo;
    logic [15:0] al_hi;
    logic [47:0] ps_data;
    logic [15:0] vis;
    logic [15:0] ir;
    logic [16:0] sync1;
    logic [16:0] sync2;
    logic [15:0] rdata;
    logic        irq;
    logic [2:0]  led_on;
    logic        integ;
    logic [1:0]  sel;
    logic        rng;
  } pam_state_s;

endpackage

// ### design/pam_seq.sv
/*
  Measurement sequencer: forced and autonomous proximity and ambient
  conversions, result registers, overflow report and interrupts.
  Assumes an external ADC whose result and overflow flag are stable
  at the end of each integration window.
*/
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps

module pam_seq #(
  parameter int BASE_CYC = pam_pkg::BASE_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [15:0] rd_data,
  // ADC and LED drivers
  input  wire logic [15:0] adc_data,
  input  wire logic        adc_ovf,
  output logic             adc_integrate,
  output logic      [1:0]  adc_channel,
  output logic             adc_high_range,
  output logic      [2:0]  led_on,
  output logic      [11:0] led_current,
  // Interrupt
  output logic             irq
);

  pam_pkg::pam_state_s q;
  pam_pkg::pam_state_s n;
  logic [15:0] res;
  logic [15:0] thr;
  logic [3:0]  cfg;
  logic [2:0]  ovf_set;
  logic [4:0]  flg_set;
  logic        above;
  logic        tick_p;
  logic        win_hit;

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n       = q;
    ovf_set = 3'h0;
    flg_set = 5'h00;
    above   = 1'b0;
    win_hit = 1'b0;
    n.sync1 = {adc_ovf, adc_data};
    n.sync2 = q.sync1;
    n.rdata = 16'h0000;
    n.irq   = |(q.ists & q.icfg[4:0]);
    res     = q.sync2[16] ? 16'hFFFF : q.sync2[15:0];
    thr     = q.ps_thr[{q.idx[1:0], 4'h0} +: 16];
    cfg     = (q.idx == 3'h3) ? q.vis_cfg : q.ir_cfg;
    tick_p  = (q.tick == 20'(BASE_CYC - 1));

    // Sequencer
    unique case (q.st)
      pam_pkg::PAM_IDLE: begin
        if (q.pend_ps) begin
          n.pend_ps = 1'b0;
          n.idx     = 3'h0;
          n.st      = pam_pkg::PAM_PS_NEXT;
        end else if (q.pend_al) begin
          n.pend_al = 1'b0;
          n.idx     = 3'h3;
          n.st      = pam_pkg::PAM_AL_NEXT;
        end
      end
      pam_pkg::PAM_PS_NEXT: begin
        if (q.idx == 3'h3) begin
          flg_set[pam_pkg::IC_SET] = 1'b1;
          n.st = pam_pkg::PAM_IDLE;
        end else if (q.channel_enable_list[q.idx]) begin
          n.cnt    = 20'(BASE_CYC - 1);
          n.led_on = q.ledsel[3 * q.idx[1:0] +: 3];
          n.integ  = 1'b1;
          n.sel    = pam_pkg::CH_PS;
          n.rng    = 1'b0;
          n.st     = pam_pkg::PAM_CONV;
        end else begin
          n.idx = q.idx + 3'h1;
        end
      end
      pam_pkg::PAM_AL_NEXT: begin
        if (q.idx == 3'h5) begin
          n.st = pam_pkg::PAM_IDLE;
        end else if (q.channel_enable_list[q.idx]) begin
          n.cnt   = (20'(BASE_CYC) << cfg[2:0]) - 20'h00001;
          n.integ = 1'b1;
          n.sel   = (q.idx == 3'h3) ? pam_pkg::CH_VIS : pam_pkg::CH_IR;
          n.rng   = cfg[3];
          n.st    = pam_pkg::PAM_CONV;
        end else begin
          n.idx = q.idx + 3'h1;
        end
      end
      pam_pkg::PAM_CONV: begin
        if (q.cnt != 20'h00000) begin
          n.cnt = q.cnt - 20'h00001;
        end else begin
          n.integ  = 1'b0;
          n.led_on = 3'h0;
          n.idx    = q.idx + 3'h1;
          if (q.idx < 3'h3) begin
            n.st = pam_pkg::PAM_PS_NEXT;
            n.ps_data[{q.idx[1:0], 4'h0} +: 16] = res;
            ovf_set[0] = q.sync2[16];
            above = (res >= thr);
            n.ps_above[q.idx[1:0]] = above;
            if (q.icfg[q.idx[1:0]] && above != q.ps_above[q.idx[1:0]]) begin
              flg_set[q.idx[1:0]] = 1'b1;
            end
          end else begin
            n.st = pam_pkg::PAM_AL_NEXT;
            if (q.idx == 3'h3) begin
              n.vis      = res;
              ovf_set[1] = q.sync2[16];
            end else begin
              n.ir       = res;
              ovf_set[2] = q.sync2[16];
            end
            win_hit = (res < q.al_lo) || (res > q.al_hi);
            if (!q.icfg[pam_pkg::IC_WIN]) begin
              flg_set[pam_pkg::IC_ALS] = 1'b1;
            end else if (q.icfg[pam_pkg::IC_WSEL] == (q.idx == 3'h4)) begin
              flg_set[pam_pkg::IC_ALS] = win_hit;
            end
          end
        end
      end
    endcase

    // Register writes
    if (wr_en) begin
      case (addr)
        pam_pkg::A_CMD: begin
          case (wr_data[3:0])
            pam_pkg::C_NOP:   n.resp = 3'h0;
            pam_pkg::C_PS:    n.pend_ps = 1'b1;
            pam_pkg::C_ALS:   n.pend_al = 1'b1;
            pam_pkg::C_PSALS: begin
              n.pend_ps = 1'b1;
              n.pend_al = 1'b1;
            end
            pam_pkg::C_AUTO:  begin
              n.auto_ps = 1'b1;
              n.auto_al = 1'b1;
            end
            pam_pkg::C_PAUSE: begin
              n.auto_ps = 1'b0;
              n.auto_al = 1'b0;
            end
            default: ;
          endcase
        end
        pam_pkg::A_CHANNEL_ENABLE_LIST:  n.channel_enable_list = wr_data[4:0];
        pam_pkg::A_LEDSEL:  n.ledsel = wr_data[8:0];
        pam_pkg::A_LEDCUR:  n.ledcur = wr_data[11:0];
        pam_pkg::A_ICFG:    n.icfg = wr_data[6:0];
        pam_pkg::A_ISTS:    n.ists = q.ists & ~wr_data[4:0];
        pam_pkg::A_PS_RATE: n.ps_rate = wr_data;
        pam_pkg::A_AL_RATE: n.al_rate = wr_data;
        pam_pkg::A_VIS_CFG: n.vis_cfg = wr_data[3:0];
        pam_pkg::A_IR_CFG:  n.ir_cfg = wr_data[3:0];
        pam_pkg::A_PS_THR0: n.ps_thr[15:0] = wr_data;
        pam_pkg::A_PS_THR1: n.ps_thr[31:16] = wr_data;
        pam_pkg::A_PS_THR2: n.ps_thr[47:32] = wr_data;
        pam_pkg::A_AL_LO:   n.al_lo = wr_data;
        pam_pkg::A_AL_HI:   n.al_hi = wr_data;
        default: ;
      endcase
    end

    // Register reads
    if (rd_en) begin
      case (addr)
        pam_pkg::A_RESP:    n.rdata = {13'h0000, q.resp};
        pam_pkg::A_CHANNEL_ENABLE_LIST:  n.rdata = {11'h000, q.channel_enable_list};
        pam_pkg::A_LEDSEL:  n.rdata = {7'h00, q.ledsel};
        pam_pkg::A_LEDCUR:  n.rdata = {4'h0, q.ledcur};
        pam_pkg::A_ICFG:    n.rdata = {9'h000, q.icfg};
        pam_pkg::A_ISTS:    n.rdata = {11'h000, q.ists};
        pam_pkg::A_PS_RATE: n.rdata = q.ps_rate;
        pam_pkg::A_AL_RATE: n.rdata = q.al_rate;
        pam_pkg::A_VIS_CFG: n.rdata = {12'h000, q.vis_cfg};
        pam_pkg::A_IR_CFG:  n.rdata = {12'h000, q.ir_cfg};
        pam_pkg::A_PS_THR0: n.rdata = q.ps_thr[15:0];
        pam_pkg::A_PS_THR1: n.rdata = q.ps_thr[31:16];
        pam_pkg::A_PS_THR2: n.rdata = q.ps_thr[47:32];
        pam_pkg::A_AL_LO:   n.rdata = q.al_lo;
        pam_pkg::A_AL_HI:   n.rdata = q.al_hi;
        pam_pkg::A_PS_DAT0: n.rdata = q.ps_data[15:0];
        pam_pkg::A_PS_DAT1: n.rdata = q.ps_data[31:16];
        pam_pkg::A_PS_DAT2: n.rdata = q.ps_data[47:32];
        pam_pkg::A_VIS_DAT: n.rdata = q.vis;
        pam_pkg::A_IR_DAT:  n.rdata = q.ir;
        default:            n.rdata = 16'h0000;
      endcase
    end

    // Autonomous timers, in base integration ticks
    n.tick = tick_p ? 20'h00000 : q.tick + 20'h00001;
    if (!q.auto_ps || q.ps_rate == 16'h0000) begin
      n.ps_tmr = 16'h0000;
    end else if (tick_p) begin
      if (q.ps_tmr >= q.ps_rate - 16'h0001) begin
        n.ps_tmr  = 16'h0000;
        n.pend_ps = 1'b1;
      end else begin
        n.ps_tmr = q.ps_tmr + 16'h0001;
      end
    end
    if (!q.auto_al || q.al_rate == 16'h0000) begin
      n.al_tmr = 16'h0000;
    end else if (tick_p) begin
      if (q.al_tmr >= q.al_rate - 16'h0001) begin
        n.al_tmr  = 16'h0000;
        n.pend_al = 1'b1;
      end else begin
        n.al_tmr = q.al_tmr + 16'h0001;
      end
    end

    // Hardware sets win over software clears
    n.resp = n.resp | ovf_set;
    n.ists = n.ists | flg_set;
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q         <= '0;
      q.st      <= pam_pkg::PAM_IDLE;
      q.channel_enable_list  <= pam_pkg::RST_CHANNEL_ENABLE_LIST;
      q.ledsel  <= pam_pkg::RST_LEDSEL;
      q.ledcur  <= pam_pkg::RST_LEDCUR;
      q.vis_cfg <= pam_pkg::RST_INTEG;
      q.ir_cfg  <= pam_pkg::RST_INTEG;
    end else begin
      q <= n;
    end
  end

  assign rd_data        = q.rdata;
  assign adc_integrate  = q.integ;
  assign adc_channel    = q.sel;
  assign adc_high_range = q.rng;
  assign led_on         = q.led_on;
  assign led_current    = q.ledcur;
  assign irq            = q.irq;

  ////////////////////////////////////////////////////////////////////
  // Checks
  logic [19:0] ilen;
  logic [19:0] iexp;
  logic        conv_end;
  logic        nop_wr;
  logic        in_win;

  assign conv_end = (q.st == pam_pkg::PAM_CONV) && (q.cnt == 20'h00000);
  assign nop_wr   = wr_en && addr == pam_pkg::A_CMD && wr_data[3:0] == pam_pkg::C_NOP;
  assign in_win   = (res >= q.al_lo) && (res <= q.al_hi);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ilen <= 20'h00000;
      iexp <= 20'h00000;
    end else begin
      ilen <= q.integ ? ilen + 20'h00001 : 20'h00000;
      if (!q.integ && n.integ) begin
        iexp <= n.cnt + 20'h00001;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_vis_ovf;
    conv_end && q.idx == 3'h3 && q.sync2[16];
  endsequence
  sequence s_vis_ok;
    conv_end && q.idx == 3'h3 && !q.sync2[16];
  endsequence
  sequence s_psals;
    wr_en && addr == pam_pkg::A_CMD && wr_data[3:0] == pam_pkg::C_PSALS;
  endsequence
  sequence s_amb_end;
    conv_end && q.idx >= 3'h3 && q.icfg[pam_pkg::IC_WIN];
  endsequence
  sequence s_win_watch;
    q.icfg[pam_pkg::IC_WSEL] == (q.idx == 3'h4);
  endsequence
  sequence s_win_out;
    s_amb_end ##0 s_win_watch ##0 !in_win;
  endsequence
  sequence s_win_in;
    s_amb_end ##0 s_win_watch ##0 (in_win && !wr_en);
  endsequence
  sequence s_win_other;
    s_amb_end ##0 (!wr_en && q.icfg[pam_pkg::IC_WSEL] != (q.idx == 3'h4));
  endsequence
  sequence s_ps_quiet;
    conv_end && q.idx < 3'h3 && !wr_en && !q.icfg[q.idx[1:0]];
  endsequence
  sequence s_ps_due;
    q.auto_ps && tick_p && q.ps_rate != 16'h0000 && q.ps_tmr == q.ps_rate - 16'h0001;
  endsequence
  sequence s_al_due;
    q.auto_al && tick_p && q.al_rate != 16'h0000 && q.al_tmr == q.al_rate - 16'h0001;
  endsequence

  ovf_saturate_a: assert property (s_vis_ovf |=> q.vis == 16'hFFFF && q.resp[1])
    else $error("overflow did not saturate result");
  result_normal_a: assert property (s_vis_ok |=> q.vis == $past(q.sync2[15:0]))
    else $error("in-range result not stored");
  ovf_sticky_a: assert property (q.resp != 3'h0 && !nop_wr |=> (q.resp & $past(q.resp)) == $past(q.resp))
    else $error("overflow flag lost without no-op");
  nop_clears_a: assert property (nop_wr && !conv_end |=> q.resp == 3'h0)
    else $error("no-op did not clear overflow");
  ps_enabled_a: assert property (q.st == pam_pkg::PAM_CONV && q.idx < 3'h3 |-> q.channel_enable_list[q.idx])
    else $error("disabled proximity channel converted");
  ir_skip_a: assert property (q.st == pam_pkg::PAM_CONV && q.idx == 3'h4 |-> q.channel_enable_list[4])
    else $error("disabled infrared channel converted");
  irq_gate_a: assert property (!(|(q.ists & q.icfg[4:0])) |=> !q.irq)
    else $error("interrupt without enabled source");
  irq_hold_a: assert property (q.irq && !$past(wr_en) |=> q.irq)
    else $error("interrupt dropped without host clear");
  integ_len_a: assert property ($fell(q.integ) |-> ilen == iexp)
    else $error("integration length wrong");
  psals_start_a: assert property (s_psals |=> q.pend_ps && q.pend_al)
    else $error("combined command did not start both");

  // Ambient window, proximity flags, LEDs, stored results and timers
  win_hit_a: assert property (s_win_out |=> q.ists[pam_pkg::IC_ALS])
    else $error("window crossing not flagged");
  win_inside_a: assert property (s_win_in |=> $stable(q.ists[pam_pkg::IC_ALS]))
    else $error("flag raised inside window");
  win_other_a: assert property (s_win_other |=> $stable(q.ists[pam_pkg::IC_ALS]))
    else $error("window applied to unselected channel");
  ps_thr_off_a: assert property (s_ps_quiet |=> $stable(q.ists[2:0]))
    else $error("disabled proximity threshold flagged");
  set_done_a: assert property (q.st == pam_pkg::PAM_PS_NEXT && q.idx == 3'h3
    |=> q.ists[pam_pkg::IC_SET])
    else $error("finished proximity set not flagged");
  led_idle_a: assert property (!q.integ || q.sel != pam_pkg::CH_PS
    |-> q.led_on == 3'h0)
    else $error("LED lit outside proximity window");
  ir_store_a: assert property (conv_end && q.idx == 3'h4 |=> q.ir == $past(res))
    else $error("infrared result not stored");
  auto_ps_a: assert property (s_ps_due |=> q.pend_ps && q.ps_tmr == 16'h0000)
    else $error("proximity timer did not start a cycle");
  auto_al_a: assert property (s_al_due |=> q.pend_al && q.al_tmr == 16'h0000)
    else $error("ambient timer did not start a cycle");

endmodule

// ### verification/pam_adc_model.sv
/*
  Photodiode and ADC front end as seen by the sequencer.
  Assumes the bench sets the light levels between conversions.
*/
`timescale 1ns/100ps
module pam_adc_model (
  // Sequencer side
  input  wire logic [1:0]  adc_channel,
  input  wire logic        adc_integrate,
  input  wire logic [2:0]  led_on,
  // Scene
  input  wire logic [15:0] lvl_ps,
  input  wire logic [15:0] lvl_vis,
  input  wire logic [15:0] lvl_ir,
  input  wire logic        sat,
  // Result
  output logic      [15:0] adc_data,
  output logic             adc_ovf
);
  logic [15:0] pick;
  // Reflection adds the led_on code, read as a number
  always_comb begin
    case (adc_channel)
      pam_pkg::CH_VIS: pick = lvl_vis;
      pam_pkg::CH_IR:  pick = lvl_ir;
      default:         pick = lvl_ps + 16'(led_on);
    endcase
  end
  // No valid result outside a window
  assign adc_data = adc_integrate ? pick : ~pick;
  assign adc_ovf  = adc_integrate & sat;
endmodule

// ### verification/tb_top.sv
/*
  Self-checking bench for the measurement sequencer.
  Assumes BASE_CYC shortened to 8 and the ADC model beside it.
*/
`timescale 1ns/100ps
module tb_top;
  localparam int BC = 8;
  logic        ref_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic        wr_en   = 1'b0;
  logic        rd_en   = 1'b0;
  logic [15:0] lvl_ps  = 16'h0120;
  logic [15:0] lvl_vis = 16'hC450;
  logic [15:0] lvl_ir  = 16'h0780;
  logic        sat     = 1'b0;
  logic [15:0] rd_data, adc_data;
  logic [1:0]  adc_channel;
  logic [2:0]  led_on;
  logic [11:0] led_current;
  logic        adc_ovf, adc_integrate, adc_high_range, irq;
  logic [2:0]  led_q [3];
  logic        hr_q [3];
  int          w_q [3];
  int          n_fail = 0;
  int          num_checks = 0;

  always #4 ref_clk = ~ref_clk;

  pam_seq #(.BASE_CYC(BC)) pam_seq_inst (
    .ref_clk, .rstn, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .adc_data,
    .adc_ovf, .adc_integrate, .adc_channel, .adc_high_range, .led_on,
    .led_current, .irq
  );
  pam_adc_model pam_adc_model_inst (
    .adc_channel, .adc_integrate, .led_on, .lvl_ps, .lvl_vis, .lvl_ir, .sat,
    .adc_data, .adc_ovf
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= v;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
  endtask

  task automatic cmd(input logic [3:0] c);
    wr(pam_pkg::A_CMD, 16'(c));
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e, input string s);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk(s, e, rd_data);
  endtask

  // Follows n integration windows, noting LEDs, range and length
  task automatic conv(input int n);
    int t;
    t = 0;
    for (int i = 0; i < n; i++) begin
      while (adc_integrate !== 1'b1 && t < 3000) begin
        @(posedge ref_clk);
        #1;
        t++;
      end
      led_q[i] = led_on;
      hr_q[i]  = adc_high_range;
      w_q[i]   = 0;
      do begin
        @(posedge ref_clk);
        #1;
        w_q[i]++;
        t++;
      end while (adc_integrate === 1'b1 && t < 3000);
    end
    repeat (3) @(posedge ref_clk);
    chk("conv wait", 16'h0000, 16'(t >= 3000));
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rchk(pam_pkg::A_CHANNEL_ENABLE_LIST, 16'h001F, "channel_enable_list");
    rchk(pam_pkg::A_LEDSEL, 16'h0111, "ledsel");
    rchk(pam_pkg::A_VIS_CFG, 16'h0000, "integ");
    rchk(8'h3C, 16'h0000, "unmapped");
    wr(pam_pkg::A_RESP, 16'h0007);
    rchk(pam_pkg::A_RESP, 16'h0000, "resp ro");
    wr(pam_pkg::A_LEDCUR, 16'h0A53);
    rchk(pam_pkg::A_LEDCUR, 16'h0A53, "ledcur");
    wr(pam_pkg::A_LEDCUR, 16'h0A73);
    rchk(pam_pkg::A_LEDCUR, 16'h0A73, "ledcur");
    chk("led cur", 16'h0A73, 16'(led_current));
    $display("end regs");
  endtask

  task automatic t_prox();
    wr(pam_pkg::A_CHANNEL_ENABLE_LIST, 16'h0005);
    wr(pam_pkg::A_LEDSEL, 16'h0047);
    wr(pam_pkg::A_PS_THR0, 16'h0200);
    wr(pam_pkg::A_PS_THR2, 16'h0100);
    wr(pam_pkg::A_ICFG, 16'h000D);
    cmd(pam_pkg::C_PS);
    conv(2);
    chk("led ch0", 16'h0007, 16'(led_q[0]));
    chk("led ch2", 16'h0001, 16'(led_q[1]));
    rchk(pam_pkg::A_PS_DAT0, lvl_ps + 16'h0007, "ps0");
    rchk(pam_pkg::A_PS_DAT1, 16'h0000, "ps1");
    rchk(pam_pkg::A_PS_DAT2, lvl_ps + 16'h0001, "ps2");
    rchk(pam_pkg::A_ISTS, 16'h000C, "ists");
    repeat (20) @(posedge ref_clk);
    #1;
    chk("irq held", 16'h0001, 16'(irq));
    wr(pam_pkg::A_ISTS, 16'h000C);
    rchk(pam_pkg::A_ISTS, 16'h0000, "ists clr");
    chk("irq clr", 16'h0000, 16'(irq));
    $display("end prox");
  endtask

  task automatic t_ovf();
    wr(pam_pkg::A_ICFG, 16'h0000);
    wr(pam_pkg::A_CHANNEL_ENABLE_LIST, 16'h0008);
    @(posedge ref_clk) sat <= 1'b1;
    cmd(pam_pkg::C_ALS);
    conv(1);
    rchk(pam_pkg::A_VIS_DAT, 16'hFFFF, "vis sat");
    rchk(pam_pkg::A_RESP, 16'h0002, "resp ovf");
    @(posedge ref_clk) sat <= 1'b0;
    cmd(pam_pkg::C_ALS);
    conv(1);
    rchk(pam_pkg::A_VIS_DAT, lvl_vis, "vis back");
    rchk(pam_pkg::A_RESP, 16'h0002, "resp held");
    cmd(pam_pkg::C_NOP);
    rchk(pam_pkg::A_RESP, 16'h0000, "resp clr");
    $display("end ovf");
  endtask

  task automatic t_amb();
    wr(pam_pkg::A_VIS_CFG, 16'h0001);
    wr(pam_pkg::A_IR_CFG, 16'h000A);
    cmd(pam_pkg::C_ALS);
    conv(1);
    chk("vis len", 16'(2 * BC), 16'(w_q[0]));
    rchk(pam_pkg::A_IR_DAT, 16'h0000, "ir skip");
    wr(pam_pkg::A_CHANNEL_ENABLE_LIST, 16'h0019);
    cmd(pam_pkg::C_PSALS);
    conv(3);
    chk("ps len", 16'(BC), 16'(w_q[0]));
    chk("ir len", 16'(4 * BC), 16'(w_q[2]));
    chk("ranges", 16'h0001, {14'h0, hr_q[1], hr_q[2]});
    rchk(pam_pkg::A_IR_DAT, lvl_ir, "ir data");
    $display("end amb");
  endtask

  task automatic t_win();
    logic [15:0] cfg [4] = '{16'h0070, 16'h0070, 16'h0070, 16'h0010};
    logic [15:0] ir [4]  = '{16'h0400, 16'h0900, 16'h0050, 16'h0400};
    logic        ex [4]  = '{1'b0, 1'b1, 1'b1, 1'b1};
    wr(pam_pkg::A_CHANNEL_ENABLE_LIST, 16'h0018);
    wr(pam_pkg::A_AL_LO, 16'h0100);
    wr(pam_pkg::A_AL_HI, 16'h0800);
    wr(pam_pkg::A_ISTS, 16'h001F);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk) lvl_ir <= ir[i];
      wr(pam_pkg::A_ICFG, cfg[i]);
      cmd(pam_pkg::C_ALS);
      conv(2);
      rchk(pam_pkg::A_ISTS, {11'h0, ex[i], 4'h0}, "ists");
      chk("irq", {15'h0, ex[i]}, 16'(irq));
      wr(pam_pkg::A_ISTS, 16'h001F);
    end
    $display("end window");
  endtask

  task automatic t_auto();
    int gap;
    int seen;
    wr(pam_pkg::A_CHANNEL_ENABLE_LIST, 16'h0009);
    wr(pam_pkg::A_ICFG, 16'h0008);
    wr(pam_pkg::A_PS_RATE, 16'h0010);
    wr(pam_pkg::A_AL_RATE, 16'h0000);
    @(posedge ref_clk) lvl_vis <= 16'h1234;
    cmd(pam_pkg::C_AUTO);
    conv(1);
    gap = 0;
    while (adc_integrate !== 1'b1 && gap < 1000) begin
      @(posedge ref_clk);
      #1;
      gap++;
    end
    chk("ps period", 16'(16 * BC), 16'(w_q[0] + 3 + gap));
    chk("auto irq", 16'h0001, 16'(irq));
    cmd(pam_pkg::C_PAUSE);
    repeat (20) @(posedge ref_clk);
    seen = 0;
    repeat (300) begin
      @(posedge ref_clk);
      #1;
      if (adc_integrate === 1'b1) begin
        seen++;
      end
    end
    chk("paused", 16'h0000, 16'(seen));
    rchk(pam_pkg::A_VIS_DAT, 16'hC450, "no vis");
    wr(pam_pkg::A_PS_RATE, 16'h0000);
    wr(pam_pkg::A_AL_RATE, 16'h0008);
    cmd(pam_pkg::C_AUTO);
    conv(1);
    cmd(pam_pkg::C_PAUSE);
    chk("al led", 16'h0000, 16'(led_q[0]));
    rchk(pam_pkg::A_VIS_DAT, 16'h1234, "al vis");
    $display("end auto");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    t_regs();
    t_prox();
    t_ovf();
    t_amb();
    t_win();
    t_auto();
    tally_and_finish();
  end

  initial begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
endmodule
